/* tbt_defs.svh */
`ifndef TBT_DEFS_SVH
`define TBT_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define TBT_ADDR_W 8
`define TBT_OFF_ENABLE 8'h00
`define TBT_OFF_STATUS 8'h04
`define TBT_OFF_TCOUNT 8'h08
`define TBT_OFF_PRESCALE 8'h0C
`define TBT_OFF_SERIAL 8'h10
`define TBT_OFF_CORE_A 8'h14
`define TBT_OFF_CORE_B 8'h18
`define TBT_OFF_EXT 8'h1C
`define TBT_OFF_CLK_LATCH 8'h20

// ****************************************
// Field positions and masks
// ****************************************
`define TBT_STAT_OVF 0
`define TBT_STAT_IRQ 1
`define TBT_STAT_INIT 2
`define TBT_CORE_A_MASK 32'h0000_FF1F
`define TBT_CORE_B_MASK 32'h03FF_003F
`define TBT_EXT_MASK 32'h33FF_0FFF

// ****************************************
// Reset values
// ****************************************
`define TBT_EN_RST 8'h00
`define TBT_CLK_LATCH_RST 1'b1
`define TBT_WORD_RST 32'h0000_0000
`define TBT_PIN_RST 5'h1F

// ****************************************
// Timing, in instruction cycles unless noted
// ****************************************
`define TBT_CYC_PHASES 4
`define TBT_PRESCALE_DIV 4
`define TBT_TIMER_STEPS 1024
`define TBT_INIT_CYCLES 3
`define TBT_TIMER_CLR_CYCLES 10

// ****************************************
// Bus answers
// ****************************************
`define TBT_RESP_OKAY 2'b00
`define TBT_RESP_SLVERR 2'b10

`endif

/* tbt_pkg.sv */
`include "tbt_defs.svh"

package tbt_pkg;

  typedef struct packed {
    logic r_port_drive;
    logic counter_input_select;
    logic irq_source_select_hi;
    logic irq_source_select_lo;
    logic serial_out_enable;
    logic l_port_drive;
    logic irq_enable_bit;
    logic serial_counter_mode;
  } tbt_en_type;

  typedef enum logic [1:0] {
    SRC_LOW_PULSE = 2'b00,
    SRC_CLOCK_PIN = 2'b01,
    SRC_ZERO_CROSS = 2'b10,
    SRC_T_OVERFLOW = 2'b11
  } tbt_irq_src_type;

  typedef struct packed {
    logic [3:0] gport;
    logic [3:0] dout;
    logic [2:0] rsv;
    logic carry;
    logic [3:0] acc;
  } tbt_core_a_type;

  typedef struct packed {
    logic [5:0] rsv_hi;
    logic [9:0] program_counter_reg;
    logic [9:0] rsv_lo;
    logic [1:0] row;
    logic [3:0] digit;
  } tbt_core_b_type;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic [1:0] input_edge_latches;
    logic [1:0] rsv_mid;
    logic [1:0] sp;
    logic [7:0] r;
    logic [3:0] rsv_lo;
    logic [3:0] h;
    logic [7:0] q;
  } tbt_ext_type;

  typedef struct packed {
    logic [`TBT_ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [`TBT_ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } tbt_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tbt_axi_rsp_type;

endpackage

/* tbt_sync.sv */
`timescale 1ns/1ps

module tbt_sync
#(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RST_VAL = '1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= RST_VAL;
      q_out <= RST_VAL;
    end
    else
    begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end

endmodule // tbt_sync

/* tbt_top.sv */
`timescale 1ns/1ps
`include "tbt_defs.svh"
// Summary of operation
// - Irq source from select bits: low pulse, clock pin, zero cross, T ovf
// - Ten-bit time base advances per instruction cycle, overflows every 1024
// - Every time base overflow sets the overflow latch, in every mode
// - Overflow latch is tested and cleared by one status read
// - Upper eight counter bits are readable and writable by software
// - Event mode counts input two pulses; overflow still sets latch
// - Counter input select bit chooses time base or event, any time
// - Four pin inputs sampled once per instruction cycle; outputs may change on any system clock
// - Serial clock period is one instruction cycle in reset, or in shift mode with the clock latch set
// - Init clears acc, carry, D, enables, G, program counter; sets latch
// - Init sets RAM address register to row zero, digit zero
// - Init when reset pin held low three or more instruction cycles
// - Upper counter cleared in three cycles, else ten cycles and latch set
// - After init serial register shifts, output low, clock runs, irq off
// - Init clears Q, H, R, input latches; irq low pulse; time base mode
// - Init also clears upper counter, input latches, ports, stack pointer
// - Select clear: counter fed by divide-by-four; set: input two clocks it
// - Interrupt recognised only while the irq enable bit is set

module tbt_top
#(
  parameter bit TIMER_ACCESS = 1'b1
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Register bus
  input wire tbt_pkg::tbt_axi_req_type S_AXI_REQ,
  output tbt_pkg::tbt_axi_rsp_type S_AXI_RSP,
  // Pin inputs
  input wire logic INIT_N,
  input wire logic INPUT_ONE,
  input wire logic INPUT_TWO_EVENT_IN,
  input wire logic CLOCK_PIN_INPUT,
  input wire logic SERIAL_IN,
  // Serial outputs
  output logic SERIAL_CLOCK_OUT,
  output logic SERIAL_OUT,
  // Port outputs
  output logic [3:0] D_PORT,
  output logic [3:0] G_PORT,
  output logic L_PORT_DRIVE,
  output logic R_PORT_DRIVE,
  // Events and status
  output logic IRQ_RECOGNIZED,
  output logic TIMER_OVERFLOW,
  output logic INIT_ACTIVE
);

  import tbt_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [`TBT_ADDR_W-1:0] addr,
                               input logic [`TBT_ADDR_W-1:0] off);
    hit = (addr[`TBT_ADDR_W-1:2] == off[`TBT_ADDR_W-1:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] din,
                                        input logic [3:0] strb,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = din[8*i +: 8];
    end
    merge = res & mask;
  endfunction

  // ****************************************
  // Pin synchronisers and cycle sampling
  // ****************************************
  logic [4:0] pin_s;
  logic init_s;
  logic [3:0] cur_s;
  logic [3:0] samp_reg;
  logic [3:0] fall;
  logic [3:0] chg;
  logic [1:0] phase_reg;
  logic cyc_tick;

  tbt_sync #(
    .WIDTH(5),
    .RST_VAL(`TBT_PIN_RST)
  ) u_sync (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .d_in({INIT_N, INPUT_ONE, INPUT_TWO_EVENT_IN, CLOCK_PIN_INPUT,
           SERIAL_IN}),
    .q_out(pin_s)
  );

  assign init_s = pin_s[4];
  assign cur_s = pin_s[3:0];
  assign cyc_tick = (phase_reg == 2'(`TBT_CYC_PHASES - 1));

  // One instruction cycle is a fixed number of system clocks
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      phase_reg <= 2'h0;
    else if (cyc_tick)
      phase_reg <= 2'h0;
    else
      phase_reg <= phase_reg + 2'h1;
  end

  // Pins looked at once per cycle, so pulses under one cycle may be missed
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      samp_reg <= 4'hF;
    else if (cyc_tick)
      samp_reg <= cur_s;
  end

  // Index 3 input one, 2 event input, 1 clock pin, 0 serial in
  for (genvar i = 0; i < 4; i++)
  begin : g_edge
    assign fall[i] = cyc_tick & samp_reg[i] & ~cur_s[i];
    assign chg[i] = cyc_tick & (samp_reg[i] ^ cur_s[i]);
  end

  // ****************************************
  // Initialisation from the reset pin
  // ****************************************
  logic [3:0] low_cnt_reg;
  logic init_now;
  logic t_clear;
  logic init_act_reg;

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      low_cnt_reg <= 4'h0;
    else if (init_s)
      low_cnt_reg <= 4'h0;
    else if (cyc_tick && low_cnt_reg < 4'(`TBT_TIMER_CLR_CYCLES))
      low_cnt_reg <= low_cnt_reg + 4'h1;
  end

  assign init_now = (low_cnt_reg >= 4'(`TBT_INIT_CYCLES));
  // Without timer access a short pulse leaves the time base running
  assign t_clear = TIMER_ACCESS ? init_now :
                   (low_cnt_reg >= 4'(`TBT_TIMER_CLR_CYCLES));

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      init_act_reg <= 1'b0;
    else
      init_act_reg <= init_now;
  end

  // ****************************************
  // Bus slave
  // ****************************************
  logic aw_full_reg;
  logic w_full_reg;
  logic [`TBT_ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_do;
  logic rd_do;
  logic wr_err;
  logic [31:0] rd_word;
  logic rd_err;
  logic stat_rd;

  assign wr_do = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign rd_do = S_AXI_REQ.arvalid & ~rvalid_reg;
  assign stat_rd = rd_do & hit(S_AXI_REQ.araddr, `TBT_OFF_STATUS);

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (S_AXI_REQ.awvalid && !aw_full_reg)
    begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= S_AXI_REQ.awaddr;
    end
    else if (wr_do)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= `TBT_WORD_RST;
      w_strb_reg <= 4'h0;
    end
    else if (S_AXI_REQ.wvalid && !w_full_reg)
    begin
      w_full_reg <= 1'b1;
      w_data_reg <= S_AXI_REQ.wdata;
      w_strb_reg <= S_AXI_REQ.wstrb;
    end
    else if (wr_do)
      w_full_reg <= 1'b0;
  end

  assign wr_err = !(hit(aw_addr_reg, `TBT_OFF_ENABLE) ||
                    hit(aw_addr_reg, `TBT_OFF_STATUS) ||
                    hit(aw_addr_reg, `TBT_OFF_TCOUNT) ||
                    hit(aw_addr_reg, `TBT_OFF_SERIAL) ||
                    hit(aw_addr_reg, `TBT_OFF_CORE_A) ||
                    hit(aw_addr_reg, `TBT_OFF_CORE_B) ||
                    hit(aw_addr_reg, `TBT_OFF_EXT) ||
                    hit(aw_addr_reg, `TBT_OFF_CLK_LATCH));

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `TBT_RESP_OKAY;
    end
    else if (wr_do)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_err ? `TBT_RESP_SLVERR : `TBT_RESP_OKAY;
    end
    else if (S_AXI_REQ.bready)
      bvalid_reg <= 1'b0;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= `TBT_WORD_RST;
      rresp_reg <= `TBT_RESP_OKAY;
    end
    else if (rd_do)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_err ? `TBT_RESP_SLVERR : `TBT_RESP_OKAY;
    end
    else if (S_AXI_REQ.rready)
      rvalid_reg <= 1'b0;
  end

  assign S_AXI_RSP.awready = ~aw_full_reg;
  assign S_AXI_RSP.wready = ~w_full_reg;
  assign S_AXI_RSP.bvalid = bvalid_reg;
  assign S_AXI_RSP.bresp = bresp_reg;
  assign S_AXI_RSP.arready = ~rvalid_reg;
  assign S_AXI_RSP.rvalid = rvalid_reg;
  assign S_AXI_RSP.rdata = rdata_reg;
  assign S_AXI_RSP.rresp = rresp_reg;

  // ****************************************
  // Program-visible state
  // ****************************************
  tbt_en_type en_reg;
  logic serial_clock_latch_reg;
  logic [31:0] core_a_reg;
  logic [31:0] core_b_reg;
  logic [31:0] ext_reg;
  tbt_core_a_type core_a;

  assign core_a = tbt_core_a_type'(core_a_reg[15:0]);

  // Init holds all of this cleared, the clock latch set, for as long as the pin stays low
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      en_reg <= tbt_en_type'(`TBT_EN_RST);
    else if (init_now)
      en_reg <= tbt_en_type'(`TBT_EN_RST);
    else if (wr_do && hit(aw_addr_reg, `TBT_OFF_ENABLE))
      en_reg <= tbt_en_type'(8'(merge(32'(en_reg), w_data_reg,
                                      w_strb_reg, 32'h0000_00FF)));
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      serial_clock_latch_reg <= `TBT_CLK_LATCH_RST;
    else if (init_now)
      serial_clock_latch_reg <= `TBT_CLK_LATCH_RST;
    else if (wr_do && hit(aw_addr_reg, `TBT_OFF_CLK_LATCH) && w_strb_reg[0])
      serial_clock_latch_reg <= w_data_reg[0];
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      core_a_reg <= `TBT_WORD_RST;
      core_b_reg <= `TBT_WORD_RST;
      ext_reg <= `TBT_WORD_RST;
    end
    else if (init_now)
    begin
      core_a_reg <= `TBT_WORD_RST;
      core_b_reg <= `TBT_WORD_RST;
      ext_reg <= `TBT_WORD_RST;
    end
    else if (wr_do)
    begin
      if (hit(aw_addr_reg, `TBT_OFF_CORE_A))
        core_a_reg <= merge(core_a_reg, w_data_reg, w_strb_reg,
                            `TBT_CORE_A_MASK);
      if (hit(aw_addr_reg, `TBT_OFF_CORE_B))
        core_b_reg <= merge(core_b_reg, w_data_reg, w_strb_reg,
                            `TBT_CORE_B_MASK);
      if (hit(aw_addr_reg, `TBT_OFF_EXT))
        ext_reg <= merge(ext_reg, w_data_reg, w_strb_reg, `TBT_EXT_MASK);
    end
  end

  // ****************************************
  // Time base and upper counter
  // ****************************************
  logic [1:0] pre_reg;
  logic [7:0] t_reg;
  logic t_wr;
  logic t_step;
  logic t_ovf;
  logic ovf_latch_reg;

  assign t_wr = wr_do & hit(aw_addr_reg, `TBT_OFF_TCOUNT) & w_strb_reg[0];
  // Event mode takes input two edges, else the prescaler carry
  assign t_step = en_reg.counter_input_select ? fall[2] :
                  (cyc_tick &&
                   pre_reg == 2'(`TBT_PRESCALE_DIV - 1));
  assign t_ovf = t_step & (t_reg == 8'hFF) & ~t_wr & ~t_clear;

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      pre_reg <= 2'h0;
    else if (t_clear)
      pre_reg <= 2'h0;
    else if (cyc_tick)
      pre_reg <= pre_reg + 2'h1;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      t_reg <= 8'h00;
    else if (t_clear)
      t_reg <= 8'h00;
    else if (t_wr)
      t_reg <= w_data_reg[7:0];
    else if (t_step)
      t_reg <= t_reg + 8'h01;
  end

  // Set beats the read clear so no overflow slips past a test
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      ovf_latch_reg <= 1'b0;
    else if (t_ovf || (!TIMER_ACCESS && t_clear))
      ovf_latch_reg <= 1'b1;
    else if (stat_rd)
      ovf_latch_reg <= 1'b0;
  end

  // ****************************************
  // Interrupt source selection
  // ****************************************
  tbt_irq_src_type irq_src;
  logic src_evt;
  logic irq_flag_reg;
  logic irq_pulse_reg;
  logic ovf_pulse_reg;
  logic irq_clr;

  assign irq_src = tbt_irq_src_type'({en_reg.irq_source_select_hi,
                                      en_reg.irq_source_select_lo});
  assign irq_clr = wr_do & hit(aw_addr_reg, `TBT_OFF_STATUS) &
                   w_strb_reg[0] & w_data_reg[`TBT_STAT_IRQ];

  always_comb
  begin
    unique case (irq_src)
      SRC_LOW_PULSE: src_evt = fall[3];
      SRC_CLOCK_PIN: src_evt = fall[1];
      SRC_ZERO_CROSS: src_evt = chg[3];
      SRC_T_OVERFLOW: src_evt = t_ovf;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      irq_flag_reg <= 1'b0;
    else if (src_evt && en_reg.irq_enable_bit)
      irq_flag_reg <= 1'b1;
    else if (irq_clr)
      irq_flag_reg <= 1'b0;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      irq_pulse_reg <= 1'b0;
      ovf_pulse_reg <= 1'b0;
    end
    else
    begin
      irq_pulse_reg <= src_evt & en_reg.irq_enable_bit;
      ovf_pulse_reg <= t_ovf;
    end
  end

  // ****************************************
  // Serial register and serial pins
  // ****************************************
  logic [3:0] serial_shift_counter_reg;
  logic serial_clock_out_reg;
  logic so_reg;

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      serial_shift_counter_reg <= 4'h0;
    else if (wr_do && hit(aw_addr_reg, `TBT_OFF_SERIAL) && w_strb_reg[0])
      serial_shift_counter_reg <= w_data_reg[3:0];
    else if (!en_reg.serial_counter_mode && cyc_tick)
      serial_shift_counter_reg <= {serial_shift_counter_reg[2:0],
                                   cur_s[0]};
    else if (en_reg.serial_counter_mode && fall[0])
      serial_shift_counter_reg <= serial_shift_counter_reg - 4'h1;
  end

  // In reset or shift mode with the latch set, clock is high for the second half of each cycle, one clock late
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      serial_clock_out_reg <= 1'b0;
    else if (!init_s ||
             (!en_reg.serial_counter_mode && serial_clock_latch_reg))
      serial_clock_out_reg <=
        (phase_reg >= 2'(`TBT_CYC_PHASES / 2));
    else
      serial_clock_out_reg <= en_reg.serial_counter_mode &
                              serial_clock_latch_reg;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      so_reg <= 1'b0;
    else if (en_reg.serial_counter_mode)
      so_reg <= en_reg.serial_out_enable;
    else
      so_reg <= en_reg.serial_out_enable &
                serial_shift_counter_reg[3];
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb
  begin
    rd_word = `TBT_WORD_RST;
    rd_err = 1'b0;
    if (hit(S_AXI_REQ.araddr, `TBT_OFF_ENABLE))
      rd_word = 32'(en_reg);
    else if (hit(S_AXI_REQ.araddr, `TBT_OFF_STATUS))
    begin
      rd_word[`TBT_STAT_OVF] = ovf_latch_reg;
      rd_word[`TBT_STAT_IRQ] = irq_flag_reg;
      rd_word[`TBT_STAT_INIT] = init_now;
    end
    else if (hit(S_AXI_REQ.araddr, `TBT_OFF_TCOUNT))
      rd_word = 32'(t_reg);
    else if (hit(S_AXI_REQ.araddr, `TBT_OFF_PRESCALE))
      rd_word = 32'(pre_reg);
    else if (hit(S_AXI_REQ.araddr, `TBT_OFF_SERIAL))
      rd_word = 32'(serial_shift_counter_reg);
    else if (hit(S_AXI_REQ.araddr, `TBT_OFF_CORE_A))
      rd_word = core_a_reg;
    else if (hit(S_AXI_REQ.araddr, `TBT_OFF_CORE_B))
      rd_word = core_b_reg;
    else if (hit(S_AXI_REQ.araddr, `TBT_OFF_EXT))
      rd_word = ext_reg;
    else if (hit(S_AXI_REQ.araddr, `TBT_OFF_CLK_LATCH))
      rd_word = 32'(serial_clock_latch_reg);
    else
      rd_err = 1'b1;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign SERIAL_CLOCK_OUT = serial_clock_out_reg;
  assign SERIAL_OUT = so_reg;
  assign D_PORT = core_a.dout;
  assign G_PORT = core_a.gport;
  assign L_PORT_DRIVE = en_reg.l_port_drive;
  assign R_PORT_DRIVE = en_reg.r_port_drive;
  assign IRQ_RECOGNIZED = irq_pulse_reg;
  assign TIMER_OVERFLOW = ovf_pulse_reg;
  assign INIT_ACTIVE = init_act_reg;

endmodule // tbt_top

/* tbt_partner.sv */
`timescale 1ns/1ps
module tbt_partner
(
  // Clock
  input wire logic clk,
  // Pins toward the block
  output logic event_pin,
  output logic init_n
);
  initial
  begin
    event_pin = 1'b1;
    init_n = 1'b1;
  end

  // Each level lasts half cycles; four or more keeps a sampled fall
  task automatic pulses(input int n, input int half);
    repeat (n)
    begin
      event_pin <= 1'b0;
      repeat (half) @(posedge clk);
      event_pin <= 1'b1;
      repeat (half) @(posedge clk);
    end
  endtask

  // Short holds model a glitch that must not initialise
  task automatic hold(input int n);
    init_n <= 1'b0;
    repeat (n) @(posedge clk);
    init_n <= 1'b1;
  endtask
endmodule // tbt_partner

/* tbt_checker.sv */
`timescale 1ns/1ps
module tbt_checker
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Watched pins
  input wire logic INIT_N,
  input wire logic SERIAL_CLOCK_OUT,
  input wire logic SERIAL_OUT,
  input wire logic [3:0] D_PORT,
  input wire logic [3:0] G_PORT,
  input wire logic L_PORT_DRIVE,
  input wire logic R_PORT_DRIVE,
  input wire logic IRQ_RECOGNIZED,
  input wire logic TIMER_OVERFLOW,
  input wire logic INIT_ACTIVE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  // Three cycles in, since SERIAL_OUT and IRQ_RECOGNIZED lag the clearing by one
  sequence s_init_held;
    INIT_ACTIVE [*3];
  endsequence
  sequence s_serial_clock_cycle;
    SERIAL_CLOCK_OUT ##1 !SERIAL_CLOCK_OUT [*2] ##1 SERIAL_CLOCK_OUT;
  endsequence
  sequence s_long_low;
    !INIT_N [*8] ##1 !INIT_N [*8] ##1 !INIT_N [*8];
  endsequence

  property p_serial_clock_period;
    disable iff (!RESETN || INIT_N)
    INIT_ACTIVE && $rose(SERIAL_CLOCK_OUT) |=> s_serial_clock_cycle;
  endproperty
  property p_init_ports;
    s_init_held |-> D_PORT == 4'h0 && G_PORT == 4'h0 &&
      !L_PORT_DRIVE && !R_PORT_DRIVE;
  endproperty
  property p_init_quiet;
    s_init_held |-> !SERIAL_OUT && !IRQ_RECOGNIZED;
  endproperty
  property p_init_no_ovf;
    s_init_held |-> !TIMER_OVERFLOW;
  endproperty
  property p_init_entry;
    s_long_low |-> INIT_ACTIVE;
  endproperty
  property p_init_min;
    $rose(INIT_ACTIVE) |-> !$past(INIT_N, 8);
  endproperty
  property p_ovf_pulse;
    TIMER_OVERFLOW |=> !TIMER_OVERFLOW [*3];
  endproperty
  property p_irq_pulse;
    IRQ_RECOGNIZED |=> !IRQ_RECOGNIZED [*3];
  endproperty

  a_serial_clock_period: assert property (p_serial_clock_period)
    else $error("serial clock period wrong");
  a_init_ports: assert property (p_init_ports)
    else $error("ports not cleared in init");
  a_init_quiet: assert property (p_init_quiet)
    else $error("serial out or irq active in init");
  a_init_no_ovf: assert property (p_init_no_ovf)
    else $error("overflow while counter held clear");
  a_init_entry: assert property (p_init_entry)
    else $error("long low reset did not initialise");
  a_init_min: assert property (p_init_min)
    else $error("init from too short a low");
  a_ovf_pulse: assert property (p_ovf_pulse)
    else $error("overflow pulses too close");
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq pulses too close");
endmodule // tbt_checker

bind tbt_top tbt_checker i_tbt_checker (.SYS_CLK(SYS_CLK),
  .RESETN(RESETN), .INIT_N(INIT_N), .SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT),
  .SERIAL_OUT(SERIAL_OUT), .D_PORT(D_PORT), .G_PORT(G_PORT),
  .L_PORT_DRIVE(L_PORT_DRIVE), .R_PORT_DRIVE(R_PORT_DRIVE),
  .IRQ_RECOGNIZED(IRQ_RECOGNIZED), .TIMER_OVERFLOW(TIMER_OVERFLOW),
  .INIT_ACTIVE(INIT_ACTIVE));

/* tbt_top_tb.sv */
`timescale 1ns/1ps
`include "tbt_defs.svh"
module tbt_top_tb;
  import tbt_pkg::*;
  localparam logic [31:0] zero = 32'h0000_0000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic in_one = 1'b1;
  logic ck_pin = 1'b1;
  logic ev_pin, init_n, irq, ovf;
  logic [3:0] d_port, g_port;
  tbt_axi_req_type rq = '0;
  tbt_axi_rsp_type rs;
  logic [33:0] exp_q[$];
  logic [31:0] v;
  logic [7:0] offs[6] = '{`TBT_OFF_TCOUNT, `TBT_OFF_ENABLE,
    `TBT_OFF_CORE_A, `TBT_OFF_CORE_B, `TBT_OFF_EXT, `TBT_OFF_CLK_LATCH};
  int exp_irq[5] = '{1, 1, 2, 1, 0};
  int errors = 0;
  int check_count = 0;
  int seed = 2;
  int irq_cnt, ovf_n, ovf_last, ovf_gap, tgt, cyc;

  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  tbt_top i_tbt_top (.SYS_CLK(clk), .RESETN(rst_n), .S_AXI_REQ(rq),
    .S_AXI_RSP(rs), .INIT_N(init_n), .INPUT_ONE(in_one),
    .INPUT_TWO_EVENT_IN(ev_pin), .CLOCK_PIN_INPUT(ck_pin),
    .SERIAL_IN(1'b1), .SERIAL_CLOCK_OUT(), .SERIAL_OUT(), .D_PORT(d_port),
    .G_PORT(g_port), .L_PORT_DRIVE(), .R_PORT_DRIVE(),
    .IRQ_RECOGNIZED(irq), .TIMER_OVERFLOW(ovf), .INIT_ACTIVE());
  tbt_partner i_tbt_partner (.clk(clk), .event_pin(ev_pin),
    .init_n(init_n));

  task automatic chk(input logic [33:0] got, input logic [33:0] e);
    check_count++;
    if (got !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h, want %h", $time, got, e);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****
  // Bus master; ready and answers sampled at the negedge before the edge
  // ****
  task automatic bus(input bit w, input logic [7:0] a,
                     input logic [31:0] d, input logic [33:0] e);
    logic aw_ok, w_ok, ar_ok, done;
    exp_q.push_back(e);
    rq.awaddr <= a;
    rq.araddr <= a;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.awvalid <= w;
    rq.wvalid <= w;
    rq.bready <= w;
    rq.arvalid <= !w;
    rq.rready <= !w;
    do
    begin
      @(negedge clk);
      aw_ok = rs.awready;
      w_ok = rs.wready;
      ar_ok = rs.arready;
      done = w ? rs.bvalid : rs.rvalid;
      @(posedge clk);
      if (aw_ok)
        rq.awvalid <= 1'b0;
      if (w_ok)
        rq.wvalid <= 1'b0;
      if (ar_ok)
        rq.arvalid <= 1'b0;
    end
    while (!done);
    rq.bready <= 1'b0;
    rq.rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic check_table;
    for (int i = 0; i < 6; i++)
      bus(1'b0, offs[i], zero, 34'(i == 5));
    bus(1'b0, 8'h40, zero, {2'b10, zero});
  endtask

  always @(negedge clk)
  begin
    if (rs.rvalid && rq.rready)
      chk({rs.rresp, rs.rdata}, exp_q.pop_front());
    if (rs.bvalid && rq.bready)
      chk({rs.bresp, zero}, exp_q.pop_front());
    if (irq)
      irq_cnt++;
    if (ovf)
    begin
      ovf_gap = cyc - ovf_last;
      ovf_last = cyc;
      ovf_n++;
    end
  end

  // ****
  // Scenarios
  // ****
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_table;
    bus(1'b1, 8'h40, zero, {2'b10, zero});
    bus(1'b1, `TBT_OFF_ENABLE, 32'h0000_0040, 34'h0);
    v = {24'h00_0000, 8'($random(seed))};
    bus(1'b1, `TBT_OFF_TCOUNT, v, 34'h0);
    bus(1'b0, `TBT_OFF_TCOUNT, zero, {2'b00, v});
    bus(1'b1, `TBT_OFF_TCOUNT, 32'h0000_00FD, 34'h0);
    i_tbt_partner.pulses(3, 8);
    bus(1'b0, `TBT_OFF_STATUS, zero, 34'h1);
    bus(1'b0, `TBT_OFF_STATUS, zero, 34'h0);
    bus(1'b0, `TBT_OFF_TCOUNT, zero, 34'h0);
    bus(1'b1, `TBT_OFF_ENABLE, zero, 34'h0);
    tgt = ovf_n + 2;
    wait (ovf_n >= tgt);
    @(posedge clk);
    chk(34'(ovf_gap), 34'h1000);
    for (int s = 0; s < 5; s++)
    begin
      v = {26'h0, 2'(s), 2'b00, 1'(s < 4), 1'b0};
      bus(1'b1, `TBT_OFF_ENABLE, v, 34'h0);
      irq_cnt = 0;
      in_one <= 1'b0;
      ck_pin <= 1'b0;
      repeat (12) @(posedge clk);
      in_one <= 1'b1;
      ck_pin <= 1'b1;
      repeat (12) @(posedge clk);
      bus(1'b1, `TBT_OFF_TCOUNT, 32'h0000_00FF, 34'h0);
      repeat (40) @(posedge clk);
      chk(34'(irq_cnt), 34'(exp_irq[s]));
    end
    v = $random(seed) & `TBT_CORE_A_MASK;
    bus(1'b1, `TBT_OFF_CORE_A, v, 34'h0);
    @(negedge clk);
    chk(34'({g_port, d_port}), 34'(v[15:8]));
    @(posedge clk);
    i_tbt_partner.hold(6);
    repeat (8) @(posedge clk);
    bus(1'b0, `TBT_OFF_CORE_A, zero, {2'b00, v});
    bus(1'b1, `TBT_OFF_CLK_LATCH, zero, 34'h0);
    bus(1'b1, `TBT_OFF_ENABLE, 32'h0000_00FF, 34'h0);
    fork
      i_tbt_partner.hold(80);
      begin
        repeat (30) @(posedge clk);
        check_table;
      end
    join
    finish_test;
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    finish_test;
  end
endmodule // tbt_top_tb
